// >>> core/serial_to_parallel_latched_shifter.sv
// Summary of operation
// (RULE1) Eight shift stages feed an eight-bit storage register driving the parallel outputs.
// (RULE2) Shift chain and storage register each have their own independent clock.
// (RULE3) Each rising shift clock edge takes serial input and advances the chain.
// (RULE4) Each rising storage clock edge copies all eight chain bits to storage.
// (RULE5) Low clear zeroes the chain at once; storage register is untouched.
// (RULE6) Last stage drives a separate cascade output for chaining devices.
// (RULE7) Output enable high floats parallel outputs; low shows the storage register.
// (RULE8) Output enable never changes chain or storage contents.
// (RULE9) Serial data enters stage a, moves toward stage h, cascade follows h.
`timescale 1ns/100ps
`default_nettype none
`include "shifter_consts.svh"

module serial_to_parallel_latched_shifter
    import shifter_pkg::*;
#(
    parameter int STAGES = `SHIFTER_STAGES
)
(
    input  wire logic     core_clk,
    input  wire logic     rst_n,
    input  wire logic     core_ce,
    input  wire logic     shift_clock,
    input  wire logic     serial_in,
    input  wire logic     shift_chain_clear_n,
    input  wire logic     storage_clock,
    input  wire logic     output_enable_n,
    output var  logic     cascade_out,
    output var  par_out_s par_out,
    output var  logic     par_out_oe
);

    // ------------------------------------------------------------
    // Shift domain: chain on the shift clock
    // ------------------------------------------------------------
    chain_t chain_q;
    chain_t chain_d;
    logic   shift_tgl_q;
    logic   shift_tgl_d;
    logic   chain_rst_n;

    // Clear acts without any shift edge
    assign chain_rst_n = rst_n & shift_chain_clear_n;

    always_comb
    begin
        chain_d     = {chain_q[`SHIFTER_LAST_STAGE-1:`SHIFTER_FIRST_STAGE], serial_in}; // [RULE3] [RULE9]
        shift_tgl_d = ~shift_tgl_q;
    end

    always_ff @(posedge shift_clock or negedge chain_rst_n)
    begin
        if (!chain_rst_n)
        begin
            chain_q     <= `SHIFTER_CHAIN_RST; // [RULE5]
            shift_tgl_q <= 1'b0;
        end
        else
        begin
            chain_q     <= chain_d; // [RULE2]
            shift_tgl_q <= shift_tgl_d;
        end
    end

    assign cascade_out = chain_q[STAGES-1]; // [RULE6] [RULE9]

    // ------------------------------------------------------------
    // Chain crossing: bus and shift toggle into the core domain
    // ------------------------------------------------------------
    chain_t chain_s1_q;
    chain_t chain_s1_d;
    chain_t chain_s2_q;
    chain_t chain_s2_d;
    chain_t chain_s3_q;
    chain_t chain_s3_d;
    logic   tgl_s1_q;
    logic   tgl_s1_d;
    logic   tgl_s2_q;
    logic   tgl_s2_d;
    logic   tgl_s3_q;
    logic   tgl_s3_d;
    logic   tgl_s4_q;
    logic   tgl_s4_d;

    always_comb
    begin
        chain_s1_d = chain_q;
        chain_s2_d = chain_s1_q;
        chain_s3_d = chain_s2_q;
        tgl_s1_d   = shift_tgl_q;
        tgl_s2_d   = tgl_s1_q;
        tgl_s3_d   = tgl_s2_q;
        tgl_s4_d   = tgl_s3_q;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chain_s1_q <= `SHIFTER_CHAIN_RST;
            chain_s2_q <= `SHIFTER_CHAIN_RST;
            chain_s3_q <= `SHIFTER_CHAIN_RST;
            tgl_s1_q   <= 1'b0;
            tgl_s2_q   <= 1'b0;
            tgl_s3_q   <= 1'b0;
            tgl_s4_q   <= 1'b0;
        end
        else if (core_ce)
        begin
            chain_s1_q <= chain_s1_d;
            chain_s2_q <= chain_s2_d;
            chain_s3_q <= chain_s3_d;
            tgl_s1_q   <= tgl_s1_d;
            tgl_s2_q   <= tgl_s2_d;
            tgl_s3_q   <= tgl_s3_d;
            tgl_s4_q   <= tgl_s4_d;
        end
    end

    // ------------------------------------------------------------
    // Storage clock pin synchroniser and edge delay
    // ------------------------------------------------------------
    logic   st_s1_q;
    logic   st_s1_d;
    logic   st_s2_q;
    logic   st_s2_d;
    logic   st_s3_q;
    logic   st_s3_d;

    always_comb
    begin
        st_s1_d = storage_clock;
        st_s2_d = st_s1_q;
        st_s3_d = st_s2_q;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_s1_q <= 1'b0;
            st_s2_q <= 1'b0;
            st_s3_q <= 1'b0;
        end
        else if (core_ce)
        begin
            st_s1_q <= st_s1_d;
            st_s2_q <= st_s2_d;
            st_s3_q <= st_s3_d;
        end
    end

    // ------------------------------------------------------------
    // Output enable pin synchroniser
    // ------------------------------------------------------------
    logic   oe_s1_q;
    logic   oe_s1_d;
    logic   oe_s2_q;
    logic   oe_s2_d;

    always_comb
    begin
        oe_s1_d = output_enable_n;
        oe_s2_d = oe_s1_q;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oe_s1_q <= 1'b1;
            oe_s2_q <= 1'b1;
        end
        else if (core_ce)
        begin
            oe_s1_q <= oe_s1_d;
            oe_s2_q <= oe_s2_d;
        end
    end

    // ------------------------------------------------------------
    // Core domain: chain copy, storage register, output enable
    // ------------------------------------------------------------
    chain_t copy_q;
    chain_t copy_d;
    chain_t store_q;
    chain_t store_d;
    logic   oe_q;
    logic   oe_d;
    logic   chain_settled;
    logic   store_edge;

    function automatic logic rising(input logic now_v, input logic prev_v);
        rising = now_v & ~prev_v;
    endfunction : rising

    // Bus is taken only once no shift has been seen and two samples agree
    assign chain_settled = (tgl_s2_q == tgl_s3_q) && (tgl_s3_q == tgl_s4_q) && (chain_s2_q == chain_s3_q);
    assign store_edge    = rising(st_s2_q, st_s3_q);

    always_comb
    begin
        copy_d  = chain_settled ? chain_s3_q : copy_q;
        store_d = store_edge ? copy_q : store_q; // [RULE4] [RULE2]
        oe_d    = ~oe_s2_q; // [RULE7] [RULE8]
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            copy_q  <= `SHIFTER_CHAIN_RST;
            store_q <= `SHIFTER_STORE_RST;
            oe_q    <= 1'b0;
        end
        else if (core_ce)
        begin
            copy_q  <= copy_d;
            store_q <= store_d; // [RULE1] [RULE5]
            oe_q    <= oe_d;
        end
    end

    assign par_out    = par_out_s'(store_q); // [RULE1]
    assign par_out_oe = oe_q; // [RULE7]

endmodule : serial_to_parallel_latched_shifter
`default_nettype wire

// >>> core/shifter_consts.svh
`ifndef SHIFTER_CONSTS_SVH
`define SHIFTER_CONSTS_SVH

// Number of shift stages and storage bits
`define SHIFTER_STAGES      8
// Reset value of the shift chain
`define SHIFTER_CHAIN_RST   8'h00
// Reset value of the storage register
`define SHIFTER_STORE_RST   8'h00
// Index of the stage that feeds the cascade output
`define SHIFTER_LAST_STAGE  7
// Index of the stage that takes the serial input
`define SHIFTER_FIRST_STAGE 0

`endif

// >>> core/shifter_pkg.sv
`default_nettype none
`include "shifter_consts.svh"

package shifter_pkg;

    typedef logic [`SHIFTER_STAGES-1:0] chain_t;

    // Parallel outputs, output a in the low bit
    typedef struct packed {
        logic par_out_h;
        logic par_out_g;
        logic par_out_f;
        logic par_out_e;
        logic par_out_d;
        logic par_out_c;
        logic par_out_b;
        logic par_out_a;
    } par_out_s;

endpackage : shifter_pkg
`default_nettype wire

// >>> tb/shift_host.sv
`timescale 1ns/100ps
`default_nettype none
module shift_host (
    input wire logic       go,
    input wire logic [7:0] data_in,
    output var logic       shift_clock = 1'h0,
    output var logic       serial_in = 1'h0
);
    // Frame of eight bits, first bit ends in stage h; clock idles low
    always @(posedge go)
    begin
        #3;
        for (int i = 7; i >= 0; i--)
        begin
            serial_in = data_in[i];
            #7.5 shift_clock = 1'h1;
            #7.5 shift_clock = 1'h0;
        end
        serial_in = ~serial_in;
    end
endmodule : shift_host
`default_nettype wire

// >>> tb/shifter_checker.sv
`timescale 1ns/100ps
`default_nettype none
module shifter_checker
    import shifter_pkg::*;
(
    input wire logic     core_clk,
    input wire logic     rst_n,
    input wire logic     core_ce,
    input wire logic     shift_clock,
    input wire logic     serial_in,
    input wire logic     shift_chain_clear_n,
    input wire logic     storage_clock,
    input wire logic     output_enable_n,
    input wire logic     cascade_out,
    input wire par_out_s par_out,
    input wire logic     par_out_oe
);
    logic [7:0] sh_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n || !core_ce);
    always_ff @(posedge shift_clock or negedge shift_chain_clear_n or negedge rst_n)
        if (!shift_chain_clear_n || !rst_n)
            sh_q <= 8'h00;
        else
            sh_q <= {sh_q[6:0], serial_in};
    a_chain_tail: assert property (cascade_out == sh_q[7]) else $error("tail");
    a_clear_tail: assert property (!shift_chain_clear_n |-> !cascade_out) else $error("clear");
    a_store_copy: assert property ($rose(storage_clock) |-> ##5 par_out == sh_q) else $error("copy");
    a_store_hold: assert property (!storage_clock [*6] |=> $stable(par_out)) else $error("hold");
    a_clear_keep: assert property
        (!shift_chain_clear_n [*4] ##1 $rose(storage_clock) |-> ##5 par_out == 8'h00) else $error("keep");
    a_oe_off: assert property (output_enable_n [*4] |-> !par_out_oe) else $error("off");
    a_oe_on: assert property (!output_enable_n [*4] |-> par_out_oe) else $error("on");
    a_oe_steady: assert property ($stable(output_enable_n) [*5] |=> $stable(par_out_oe)) else $error("oe");
endmodule : shifter_checker
bind serial_to_parallel_latched_shifter shifter_checker i_chk (.core_clk, .rst_n, .core_ce, .shift_clock,
    .serial_in, .shift_chain_clear_n, .storage_clock, .output_enable_n, .cascade_out, .par_out, .par_out_oe);
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import shifter_pkg::*;
    logic       core_clk = 1'h0, rst_n = 1'h0, clr_n = 1'h1, st = 1'h0, oe_n = 1'h1, go = 1'h0, sclk, sdi, casc, oe;
    logic       ce = 1'h1;
    logic [7:0] d = 8'h00;
    par_out_s   po;
    int         n_fail = 0, comparisons = 0, cyc = 0;
    always #20 core_clk = ~core_clk;
    serial_to_parallel_latched_shifter i_dut (.core_clk, .rst_n, .core_ce(ce), .shift_clock(sclk), .serial_in(sdi),
        .shift_chain_clear_n(clr_n), .storage_clock(st), .output_enable_n(oe_n), .cascade_out(casc), .par_out(po),
        .par_out_oe(oe));
    shift_host i_host (.go, .data_in(d), .shift_clock(sclk), .serial_in(sdi));
    task automatic check(string n, logic [7:0] g, logic [7:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : check
    task automatic complete_run;
        $display("fails %0d checks %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    task automatic load(logic [7:0] b);
        @(posedge core_clk);
        d <= b;
        go <= 1'h1;
        repeat (12) @(posedge core_clk);
        go <= 1'h0;
        @(negedge core_clk);
    endtask : load
    task automatic store;
        @(posedge core_clk);
        st <= 1'h1;
        repeat (3) @(posedge core_clk);
        st <= 1'h0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
    endtask : store
    task automatic t_load;
        oe_n <= 1'h0;
        load(8'h96);
        check("held", po, 8'h00);
        store;
        check("par", po, 8'h96);
        check("casc", {7'h00, casc}, 8'h01);
        check("oe", {7'h00, oe}, 8'h01);
    endtask : t_load
    task automatic t_clear;
        @(posedge core_clk);
        clr_n <= 1'h0;
        @(negedge core_clk);
        check("casc", {7'h00, casc}, 8'h00);
        check("keep", po, 8'h96);
        repeat (5) @(posedge core_clk);
        store;
        check("clr", po, 8'h00);
    endtask : t_clear
    task automatic t_oe;
        @(posedge core_clk);
        clr_n <= 1'h1;
        oe_n <= 1'h1;
        load(8'h71);
        check("oe", {7'h00, oe}, 8'h00);
        store;
        @(posedge core_clk);
        oe_n <= 1'h0;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        check("oe", {7'h00, oe}, 8'h01);
        check("kept", po, 8'h71);
        check("casc", {7'h00, casc}, 8'h00);
    endtask : t_oe
    task automatic t_freeze;
        @(posedge core_clk);
        ce <= 1'h0;
        load(8'h5b);
        store;
        check("frozen", po, 8'h71);
        @(posedge core_clk);
        ce <= 1'h1;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        check("thawed", po, 8'h71);
        store;
        check("par", po, 8'h5b);
    endtask : t_freeze
    initial
    begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'h1;
        t_load;
        t_clear;
        t_oe;
        t_freeze;
        complete_run;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc > 1000)
        begin
            n_fail++;
            complete_run;
        end
    end
endmodule : tb_top
`default_nettype wire
